/* File: logic/mqfs_apb_regs.sv */
// Purpose: APB register slave of the flag-status block.
// Assumes: Zero-wait answers while the clock enable is high.
// Notes:   Unmapped offsets read zero and answer with pslverr.
`timescale 1ns/100ps
`include "mqfs_defs.svh"

module mqfs_apb_regs (
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire logic        clk_en_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Core side
  mqfs_reg_if.regs         rif
);

  logic        pkt_en_r;
  logic        prog_req_r;
  logic [31:0] prdata_r;
  logic        pslverr_r;
  logic        wr_stb;
  logic [31:0] rd_mux;
  logic        hit;

  // -----------------------------------------------------------------------
  // Decode
  // -----------------------------------------------------------------------
  // Frozen clock enable stalls the access rather than dropping it
  assign pready_o  = clk_en_i;
  assign wr_stb    = psel_i & penable_i & pwrite_i & clk_en_i;
  assign prdata_o  = prdata_r;
  assign pslverr_o = pslverr_r;
  assign rif.pkt_en   = pkt_en_r;
  assign rif.prog_req = prog_req_r;

  // Read multiplexer and address hit
  always_comb begin
    rd_mux = 32'h0000_0000;
    hit    = 1'b1;
    case (paddr_i)
      `MQFS_CTRL_OFF: begin
        rd_mux[`MQFS_CTRL_PKT_BIT]  = pkt_en_r;
        rd_mux[`MQFS_CTRL_DONE_BIT] = prog_req_r;
      end
      `MQFS_STATUS_OFF: begin
        rd_mux[`MQFS_ST_POLLED]  = rif.polled;
        rd_mux[`MQFS_ST_OFFSEL]  = rif.offsel;
        rd_mux[`MQFS_ST_DEFPROG] = rif.defprog;
        rd_mux[`MQFS_ST_CFGVAL]  = rif.cfg_valid;
        rd_mux[`MQFS_ST_DONE]    = rif.prog_done;
        rd_mux[`MQFS_ST_ID_LSB +: 3]   = rif.dev_id;
        rd_mux[`MQFS_ST_QUAD_LSB +: 2] = rif.ae_quad;
        rd_mux[`MQFS_ST_AEDRV]   = rif.ae_drive;
        rd_mux[`MQFS_ST_WROWN]   = rif.wr_own;
        rd_mux[`MQFS_ST_WRQ_LSB +: 5]  = rif.wr_q;
      end
      `MQFS_OFFSET_OFF: rd_mux[7:0] = rif.offset;
      default:          hit = 1'b0;
    endcase
  end

  // -----------------------------------------------------------------------
  // Registers
  // -----------------------------------------------------------------------
  // Answer captured in the setup cycle, stable through the access phase
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (clk_en_i && psel_i && !penable_i) begin
      prdata_r  <= pwrite_i ? 32'h0000_0000 : rd_mux;
      pslverr_r <= ~hit;
    end
  end

  // Control bits; done bit is set-only so a stray zero cannot undo it
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pkt_en_r   <= 1'(`MQFS_CTRL_RST >> `MQFS_CTRL_PKT_BIT);
      prog_req_r <= 1'b0;
    end else if (wr_stb && paddr_i == `MQFS_CTRL_OFF) begin
      pkt_en_r   <= pwdata_i[`MQFS_CTRL_PKT_BIT];
      if (pwdata_i[`MQFS_CTRL_DONE_BIT]) begin
        prog_req_r <= 1'b1;
      end
    end
  end

endmodule

/* File: logic/mqfs_defs.svh */
// Purpose: Constants of the multi-queue flag-status block.
// Assumes: Included by bare name from every design file that needs it.
// Notes:   Definitions only.

`ifndef MQFS_DEFS_SVH
`define MQFS_DEFS_SVH

// -----------------------------------------------------------------------
// Register offsets (byte addresses)
// -----------------------------------------------------------------------
`define MQFS_CTRL_OFF      12'h000
`define MQFS_STATUS_OFF    12'h004
`define MQFS_OFFSET_OFF    12'h008

// -----------------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------------
`define MQFS_CTRL_PKT_BIT  0
`define MQFS_CTRL_DONE_BIT 1
`define MQFS_ST_POLLED     0
`define MQFS_ST_OFFSEL     1
`define MQFS_ST_DEFPROG    2
`define MQFS_ST_CFGVAL     3
`define MQFS_ST_DONE       4
`define MQFS_ST_ID_LSB     5
`define MQFS_ST_QUAD_LSB   8
`define MQFS_ST_AEDRV      10
`define MQFS_ST_WROWN      11
`define MQFS_ST_WRQ_LSB    12

// -----------------------------------------------------------------------
// Reset values and counts
// -----------------------------------------------------------------------
`define MQFS_CTRL_RST      2'h0
`define MQFS_OFFSET_LOW    8'h08
`define MQFS_OFFSET_HIGH   8'h80
`define MQFS_CAPTURE_CYC   2'h3

`endif

/* File: logic/mqfs_flag_status.sv */
// Purpose: Almost-empty flag bus and full indicator of a multi-queue FIFO.
// Assumes: Read port, write port and chain neighbours share mclk_i.
// Notes:   Only the configuration straps are asynchronous and synchronised.
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/100ps
`include "mqfs_defs.svh"

module mqfs_flag_status #(
  parameter int NUM_QUEUES = 32,
  parameter int QUAD_WIDTH = 8
) (
  // Clock, enable and master reset
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire logic        clk_en_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Configuration straps
  input  wire logic        flag_bus_mode_select_i,
  input  wire logic        default_offset_select_i,
  input  wire logic        default_programming_select_i,
  input  wire logic [2:0]  device_identity_inputs_i,
  // Per-queue status from the queue logic
  input  wire logic [31:0] almost_empty_flag_i,
  input  wire logic [31:0] packet_ready_flag_i,
  input  wire logic [31:0] queue_full_i,
  // Read port
  input  wire logic [7:0]  read_queue_address_i,
  input  wire logic        empty_bus_strobe_i,
  input  wire logic        empty_token_in_i,
  output logic      [7:0]  almost_empty_bus_o,
  output logic             almost_empty_bus_oe_n_o,
  output logic             empty_bus_sync_o,
  output logic             empty_token_out_o,
  // Write port
  input  wire logic [7:0]  write_queue_address_i,
  input  wire logic        write_address_enable_i,
  output logic             full_indicator_o,
  output logic             full_indicator_oe_n_o,
  // Configuration results
  output logic             serial_program_done_o,
  output logic      [7:0]  flag_offset_o
);

  // -----------------------------------------------------------------------
  // Parameter check
  // -----------------------------------------------------------------------
  generate
    if (NUM_QUEUES != 32 || QUAD_WIDTH != 8) begin : g_bad_size
      $error("Flag bus logic serves 32 queues in quadrants of eight only");
    end
  endgenerate

  // -----------------------------------------------------------------------
  // Functions
  // -----------------------------------------------------------------------
  // Quadrant shown by a sequencer state
  function automatic logic [1:0] quad_of_state(
    input mqfs_pkg::mqfs_poll_state_type st
  );
    case (st)
      mqfs_pkg::MQFS_Q2: quad_of_state = 2'h1;
      mqfs_pkg::MQFS_Q3: quad_of_state = 2'h2;
      mqfs_pkg::MQFS_Q4: quad_of_state = 2'h3;
      default:           quad_of_state = 2'h0;
    endcase
  endfunction

  // Eight status bits of one quadrant
  function automatic logic [7:0] quad_bits(
    input logic [31:0] vec,
    input logic [1:0]  q
  );
    quad_bits = vec[{q, 3'h0} +: 8];
  endfunction

  // -----------------------------------------------------------------------
  // Declarations
  // -----------------------------------------------------------------------
  mqfs_reg_if rif ();

  logic [5:0]  strap_s1_r;
  logic [5:0]  strap_s2_r;
  logic [1:0]  cap_cnt_r;
  logic        cfg_valid_r;
  logic        polled_r;
  logic        offsel_r;
  logic        defprog_r;
  logic [2:0]  dev_id_r;
  logic [7:0]  offset_r;
  logic        prog_done_r;
  logic        start_pend_r;
  mqfs_pkg::mqfs_poll_state_type state_r;
  mqfs_pkg::mqfs_poll_state_type state_nxt;
  logic        dir_own_r;
  logic        dir_own_nxt;
  logic [1:0]  dir_quad_r;
  logic [1:0]  dir_quad_nxt;
  logic [1:0]  ae_quad_nxt;
  logic [31:0] ae_src;
  logic [7:0]  ae_bus_r;
  logic        ae_oe_n_r;
  logic        sync_r;
  logic        token_r;
  logic        wr_own_r;
  logic        wr_own_nxt;
  logic [4:0]  wr_q_r;
  logic [4:0]  wr_q_nxt;
  logic        full_ind_r;
  logic        full_oe_n_r;

  // -----------------------------------------------------------------------
  // Register slave
  // -----------------------------------------------------------------------
  mqfs_apb_regs u_regs (
    .mclk_i    (mclk_i),
    .rst_n_i   (rst_n_i),
    .clk_en_i  (clk_en_i),
    .psel_i    (psel_i),
    .penable_i (penable_i),
    .pwrite_i  (pwrite_i),
    .paddr_i   (paddr_i),
    .pwdata_i  (pwdata_i),
    .prdata_o  (prdata_o),
    .pready_o  (pready_o),
    .pslverr_o (pslverr_o),
    .rif       (rif)
  );

  // Status toward the slave
  assign rif.polled    = polled_r;
  assign rif.offsel    = offsel_r;
  assign rif.defprog   = defprog_r;
  assign rif.cfg_valid = cfg_valid_r;
  assign rif.prog_done = prog_done_r;
  assign rif.dev_id    = dev_id_r;
  assign rif.ae_quad   = polled_r ? quad_of_state(state_r) : dir_quad_r;
  assign rif.ae_drive  = ~ae_oe_n_r;
  assign rif.wr_own    = wr_own_r;
  assign rif.wr_q      = wr_q_r;
  assign rif.offset    = offset_r;

  // -----------------------------------------------------------------------
  // Configuration capture
  // -----------------------------------------------------------------------
  // Two-stage synchroniser on the straps
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strap_s1_r <= 6'h00;
      strap_s2_r <= 6'h00;
    end else if (clk_en_i) begin
      strap_s1_r <= {device_identity_inputs_i, default_programming_select_i,
                     default_offset_select_i, flag_bus_mode_select_i};
      strap_s2_r <= strap_s1_r;
    end
  end

  // Straps taken once, after the synchroniser has filled
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cap_cnt_r   <= 2'h0;
      cfg_valid_r <= 1'b0;
      polled_r    <= 1'b0;
      offsel_r    <= 1'b0;
      defprog_r   <= 1'b0;
      dev_id_r    <= 3'h0;
      offset_r    <= `MQFS_OFFSET_LOW;
    end else if (clk_en_i && !cfg_valid_r) begin
      if (cap_cnt_r == `MQFS_CAPTURE_CYC) begin
        cfg_valid_r <= 1'b1;
        polled_r    <= strap_s2_r[0];
        offsel_r    <= strap_s2_r[1];
        defprog_r   <= strap_s2_r[2];
        dev_id_r    <= strap_s2_r[5:3];
        offset_r    <= strap_s2_r[1] ? `MQFS_OFFSET_HIGH
                                     : `MQFS_OFFSET_LOW;
      end else begin
        cap_cnt_r <= cap_cnt_r + 2'h1;
      end
    end
  end

  // Programming done: at once in default mode, by software in serial mode
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prog_done_r  <= 1'b0;
      start_pend_r <= 1'b0;
    end else if (clk_en_i) begin
      if (cfg_valid_r && !prog_done_r && (defprog_r || rif.prog_req)) begin
        prog_done_r  <= 1'b1;
        // Identity zero seeds the token ring once
        start_pend_r <= polled_r && dev_id_r == 3'h0;
      end else if (state_nxt == mqfs_pkg::MQFS_Q1) begin
        start_pend_r <= 1'b0;
      end
    end
  end

  // -----------------------------------------------------------------------
  // Almost-empty bus next state
  // -----------------------------------------------------------------------
  always_comb begin
    state_nxt    = state_r;
    dir_own_nxt  = dir_own_r;
    dir_quad_nxt = dir_quad_r;
    if (!prog_done_r || !polled_r) begin
      state_nxt = mqfs_pkg::MQFS_IDLE;
    end else begin
      case (state_r)
        mqfs_pkg::MQFS_IDLE: begin
          if (empty_token_in_i || start_pend_r) begin
            state_nxt = mqfs_pkg::MQFS_Q1;
          end
        end
        mqfs_pkg::MQFS_Q1: state_nxt = mqfs_pkg::MQFS_Q2;
        mqfs_pkg::MQFS_Q2: state_nxt = mqfs_pkg::MQFS_Q3;
        mqfs_pkg::MQFS_Q3: state_nxt = mqfs_pkg::MQFS_Q4;
        mqfs_pkg::MQFS_Q4: begin
          // Looped single device wraps to quadrant 1 on the fifth edge
          state_nxt = empty_token_in_i ? mqfs_pkg::MQFS_Q1
                                       : mqfs_pkg::MQFS_IDLE;
        end
        default: state_nxt = mqfs_pkg::MQFS_IDLE;
      endcase
    end
    // Strobe honoured only once programming is over, in direct mode
    if (prog_done_r && !polled_r && empty_bus_strobe_i) begin
      dir_own_nxt  = read_queue_address_i[7:5] == dev_id_r;
      dir_quad_nxt = read_queue_address_i[4:3];
    end
    ae_quad_nxt = polled_r ? quad_of_state(state_nxt) : dir_quad_nxt;
    ae_src      = rif.pkt_en ? packet_ready_flag_i
                             : almost_empty_flag_i;
  end

  // -----------------------------------------------------------------------
  // Almost-empty bus state
  // -----------------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r    <= mqfs_pkg::MQFS_IDLE;
      dir_own_r  <= 1'b0;
      dir_quad_r <= 2'h0;
    end else if (clk_en_i) begin
      state_r    <= state_nxt;
      dir_own_r  <= dir_own_nxt;
      dir_quad_r <= dir_quad_nxt;
    end
  end

  // Bus outputs; direct mode refreshes the owned quadrant every cycle
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ae_bus_r  <= 8'h00;
      ae_oe_n_r <= 1'b1;
      sync_r    <= 1'b0;
      token_r   <= 1'b0;
    end else if (clk_en_i) begin
      ae_bus_r  <= quad_bits(ae_src, ae_quad_nxt);
      ae_oe_n_r <= polled_r ? state_nxt == mqfs_pkg::MQFS_IDLE
                            : ~dir_own_nxt;
      sync_r    <= state_nxt == mqfs_pkg::MQFS_Q1;
      token_r   <= state_nxt == mqfs_pkg::MQFS_Q4;
    end
  end

  assign almost_empty_bus_o      = ae_bus_r;
  assign almost_empty_bus_oe_n_o = ae_oe_n_r;
  assign empty_bus_sync_o        = sync_r;
  assign empty_token_out_o       = token_r;

  // -----------------------------------------------------------------------
  // Full indicator
  // -----------------------------------------------------------------------
  always_comb begin
    wr_own_nxt = wr_own_r;
    wr_q_nxt   = wr_q_r;
    if (cfg_valid_r && write_address_enable_i) begin
      wr_own_nxt = write_queue_address_i[7:5] == dev_id_r;
      wr_q_nxt   = write_queue_address_i[4:0];
    end
  end

  // High means room; output enable follows ownership on the same edge
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_own_r    <= 1'b0;
      wr_q_r      <= 5'h00;
      full_ind_r  <= 1'b0;
      full_oe_n_r <= 1'b1;
    end else if (clk_en_i) begin
      wr_own_r    <= wr_own_nxt;
      wr_q_r      <= wr_q_nxt;
      full_ind_r  <= ~queue_full_i[wr_q_nxt];
      full_oe_n_r <= ~wr_own_nxt;
    end
  end

  assign full_indicator_o      = full_ind_r;
  assign full_indicator_oe_n_o = full_oe_n_r;

  // -----------------------------------------------------------------------
  // Configuration results
  // -----------------------------------------------------------------------
  // Active-low done: high until programming has finished
  assign serial_program_done_o = ~prog_done_r;
  assign flag_offset_o         = offset_r;

endmodule

/* File: logic/mqfs_pkg.sv */
// Purpose: Types of the multi-queue flag-status block.
// Assumes: Constants live in mqfs_defs.svh.
// Notes:   Referenced only by scoped names.

package mqfs_pkg;

  // Polled sequencer, one-hot
  typedef enum logic [4:0] {
    MQFS_IDLE = 5'h01,
    MQFS_Q1   = 5'h02,
    MQFS_Q2   = 5'h04,
    MQFS_Q3   = 5'h08,
    MQFS_Q4   = 5'h10
  } mqfs_poll_state_type;

endpackage

/* File: logic/mqfs_reg_if.sv */
// Purpose: Carrier between flag core and register slave.
// Assumes: Single clock domain.
// Notes:   Status flows to the slave, controls flow to the core.
`timescale 1ns/100ps

interface mqfs_reg_if;
  logic       pkt_en;     // Packet-ready reporting
  logic       prog_req;   // Serial programming finished
  logic       polled;
  logic       offsel;
  logic       defprog;
  logic       cfg_valid;
  logic       prog_done;
  logic [2:0] dev_id;
  logic [1:0] ae_quad;
  logic       ae_drive;
  logic       wr_own;
  logic [4:0] wr_q;
  logic [7:0] offset;

  modport regs (
    output pkt_en, prog_req,
    input  polled, offsel, defprog, cfg_valid, prog_done, dev_id,
    input  ae_quad, ae_drive, wr_own, wr_q, offset
  );
  modport core (
    input  pkt_en, prog_req,
    output polled, offsel, defprog, cfg_valid, prog_done, dev_id,
    output ae_quad, ae_drive, wr_own, wr_q, offset
  );
endinterface

/* File: verification/mqfs_flag_status_monitor.sv */
// Purpose: Port checks of the flag-status block.
// Assumes: One clock; straps stable outside reset.
// Notes:   Bound to the top module at the foot.
`timescale 1ns/100ps

module mqfs_flag_status_monitor (
  // Clock, reset, straps
  input wire logic        mclk_i,
  input wire logic        rst_n_i,
  input wire logic        flag_bus_mode_select_i,
  input wire logic        default_offset_select_i,
  input wire logic        default_programming_select_i,
  input wire logic [2:0]  device_identity_inputs_i,
  input wire logic [31:0] queue_full_i,
  // Read port
  input wire logic [7:0]  read_queue_address_i,
  input wire logic        empty_bus_strobe_i,
  input wire logic        empty_token_in_i,
  input wire logic        almost_empty_bus_oe_n_o,
  input wire logic        empty_bus_sync_o,
  input wire logic        empty_token_out_o,
  // Write port and status
  input wire logic [7:0]  write_queue_address_i,
  input wire logic        write_address_enable_i,
  input wire logic        full_indicator_o,
  input wire logic        full_indicator_oe_n_o,
  input wire logic        serial_program_done_o,
  input wire logic [7:0]  flag_offset_o
);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  property p_offset;
    !serial_program_done_o && default_programming_select_i |->
      flag_offset_o == (default_offset_select_i ? 8'h80 : 8'h08);
  endproperty
  a_offset: assert property (p_offset)
    else $error("flag offset wrong");
  property p_dir_sel;
    empty_bus_strobe_i && !serial_program_done_o && !flag_bus_mode_select_i
      |=> almost_empty_bus_oe_n_o ==
        ($past(read_queue_address_i[7:5]) != device_identity_inputs_i);
  endproperty
  a_dir_sel: assert property (p_dir_sel)
    else $error("direct selection drive wrong");
  property p_full_own;
    write_address_enable_i && !serial_program_done_o |=>
      full_indicator_oe_n_o ==
        ($past(write_queue_address_i[7:5]) != device_identity_inputs_i);
  endproperty
  a_full_own: assert property (p_full_own)
    else $error("full line ownership wrong");
  property p_full_val;
    write_address_enable_i && !serial_program_done_o &&
      write_queue_address_i[7:5] == device_identity_inputs_i |=>
      full_indicator_o == !$past(queue_full_i[write_queue_address_i[4:0]]);
  endproperty
  a_full_val: assert property (p_full_val)
    else $error("full value wrong");
  property p_sync_gap;
    empty_bus_sync_o |=> !empty_bus_sync_o [*3];
  endproperty
  a_sync_gap: assert property (p_sync_gap)
    else $error("sync repeated too soon");
  property p_token_pos;
    empty_bus_sync_o && flag_bus_mode_select_i |-> ##3 empty_token_out_o;
  endproperty
  a_token_pos: assert property (p_token_pos)
    else $error("token not on fourth quadrant");
  property p_token_past;
    empty_token_out_o |-> $past(empty_bus_sync_o, 3);
  endproperty
  a_token_past: assert property (p_token_past)
    else $error("token without quadrant one earlier");
  property p_token_in;
    empty_token_in_i && flag_bus_mode_select_i && !serial_program_done_o
      |=> empty_bus_sync_o && !almost_empty_bus_oe_n_o;
  endproperty
  a_token_in: assert property (p_token_in)
    else $error("token did not load quadrant one");

  c_direct: cover property (empty_bus_strobe_i && !serial_program_done_o);
  c_loop: cover property (empty_token_out_o ##1 empty_bus_sync_o);
  c_full: cover property (write_address_enable_i && !serial_program_done_o);
endmodule

bind mqfs_flag_status mqfs_flag_status_monitor mqfs_flag_status_monitor_inst (
  .mclk_i, .rst_n_i, .flag_bus_mode_select_i, .default_offset_select_i,
  .default_programming_select_i, .device_identity_inputs_i, .queue_full_i,
  .read_queue_address_i, .empty_bus_strobe_i, .empty_token_in_i,
  .almost_empty_bus_oe_n_o, .empty_bus_sync_o, .empty_token_out_o,
  .write_queue_address_i, .write_address_enable_i, .full_indicator_o,
  .full_indicator_oe_n_o, .serial_program_done_o, .flag_offset_o
);

/* File: verification/mqfs_flag_status_tb.sv */
// Purpose: Self-checking bench of the flag-status block.
// Assumes: Device id 0, token looped by the host model.
// Notes:   Direct phase, then polled phase with serial setup.
`timescale 1ns/100ps

module mqfs_flag_status_tb;
  // ---------------------------------------------------------------
  // Nets, design and host model
  // ---------------------------------------------------------------
  logic        mclk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o, rd;
  logic        pready_o, pslverr_o, err, strobe_req = 1'b0;
  logic        flag_bus_mode_select_i = 1'b0;
  logic        default_offset_select_i = 1'b0;
  logic        default_programming_select_i = 1'b1;
  logic [31:0] almost_empty_flag_i = 32'h0;
  logic [31:0] packet_ready_flag_i = 32'h0;
  logic [31:0] queue_full_i = 32'h0;
  logic [7:0]  read_queue_address_i = 8'h00;
  logic [7:0]  write_queue_address_i = 8'h00;
  logic        write_address_enable_i = 1'b0;
  logic        empty_bus_strobe_i, empty_token_in_i, empty_bus_sync_o;
  logic [7:0]  almost_empty_bus_o, flag_offset_o;
  logic        almost_empty_bus_oe_n_o, empty_token_out_o;
  logic        full_indicator_o, full_indicator_oe_n_o;
  logic        serial_program_done_o;
  logic [7:0]  exp_q[$];
  int          errors = 0;
  int          checks_done = 0;

  always #5 mclk_i = ~mclk_i;

  mqfs_flag_status mqfs_flag_status_inst (
    .mclk_i, .rst_n_i, .clk_en_i(1'b1), .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
    .flag_bus_mode_select_i, .default_offset_select_i,
    .default_programming_select_i, .device_identity_inputs_i(3'h0),
    .almost_empty_flag_i, .packet_ready_flag_i, .queue_full_i,
    .read_queue_address_i, .empty_bus_strobe_i, .empty_token_in_i,
    .almost_empty_bus_o, .almost_empty_bus_oe_n_o, .empty_bus_sync_o,
    .empty_token_out_o, .write_queue_address_i, .write_address_enable_i,
    .full_indicator_o, .full_indicator_oe_n_o, .serial_program_done_o,
    .flag_offset_o
  );
  mqfs_host_model mqfs_host_model_inst (
    .polled_i(flag_bus_mode_select_i), .strobe_req_i(strobe_req),
    .prog_busy_i(serial_program_done_o), .token_out_i(empty_token_out_o),
    .strobe_o(empty_bus_strobe_i), .token_in_o(empty_token_in_i)
  );

  // ---------------------------------------------------------------
  // Tasks and model
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Quadrant n holds queues 8n..8n+7, lowest queue in bit 0
  function automatic logic [7:0] quad(input logic [31:0] v, input int q);
    return v[q*8 +: 8];
  endfunction
  // APB cycle after one idle edge; held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd);
    @(posedge mclk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge mclk_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  // Straps set before release and kept during the run
  task automatic do_reset(input logic fm, input logic ofs, input logic dp);
    rst_n_i <= 1'b0;
    flag_bus_mode_select_i <= fm;
    default_offset_select_i <= ofs;
    default_programming_select_i <= dp;
    repeat (12) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    repeat (8) @(posedge mclk_i);
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(75180));
    almost_empty_flag_i <= $urandom;
    packet_ready_flag_i <= $urandom;
    queue_full_i <= $urandom;
    do_reset(1'b0, 1'b1, 1'b1);
    chk("offset", flag_offset_o, 8'h80);
    chk("prog_busy", serial_program_done_o, 1'b0);
    apb(1'b0, 12'h004, 32'h0);
    chk("mode", rd[0], 1'b0);
    apb(1'b0, 12'h00C, 32'h0);
    chk("unmapped", {err, rd[30:0]}, 32'h80000000);
    // Every quadrant, then a foreign device id
    for (int q = 0; q < 5; q++) begin
      strobe_req <= 1'b1;
      read_queue_address_i <= (q == 4) ? 8'h3A : 8'(q * 9);
      @(posedge mclk_i);
      strobe_req <= 1'b0;
      #1;
      chk("ae_oe_n", almost_empty_bus_oe_n_o, q == 4);
      if (q < 4) begin
        chk("ae_bus", almost_empty_bus_o, quad(almost_empty_flag_i, q));
      end
      @(posedge mclk_i);
    end
    for (int i = 0; i < 3; i++) begin
      write_address_enable_i <= 1'b1;
      write_queue_address_i <= (i == 2) ? 8'h25 : 8'($urandom_range(31));
      @(posedge mclk_i);
      write_address_enable_i <= 1'b0;
      #1;
      chk("ff_oe_n", full_indicator_oe_n_o, i == 2);
      if (i < 2) begin
        chk("ff", full_indicator_o,
            !queue_full_i[write_queue_address_i[4:0]]);
      end
      @(posedge mclk_i);
    end
    do_reset(1'b1, 1'b0, 1'b0);
    chk("prog_busy", serial_program_done_o, 1'b1);
    chk("ae_idle", almost_empty_bus_oe_n_o, 1'b1);
    apb(1'b1, 12'h000, 32'h3);
    repeat (3) @(posedge mclk_i);
    #1;
    chk("prog_done", serial_program_done_o, 1'b0);
    for (int k = 0; k < 8; k++) exp_q.push_back(quad(packet_ready_flag_i, k % 4));
    for (int n = 0; n < 20 && empty_bus_sync_o !== 1'b1; n++) begin
      @(posedge mclk_i);
      #1;
    end
    for (int k = 0; k < 8; k++) begin
      chk("ae_bus", almost_empty_bus_o, exp_q.pop_front());
      chk("sync", empty_bus_sync_o, k % 4 == 0);
      chk("token", empty_token_out_o, k % 4 == 3);
      @(posedge mclk_i);
      #1;
    end
    stop_test();
  end

  // Whole run is under a hundred cycles
  initial begin
    #20000;
    errors++;
    stop_test();
  end
endmodule

/* File: verification/mqfs_host_model.sv */
// Purpose: Host side of the read port and the token loop.
// Assumes: Single device looping its own token.
// Notes:   Strobe gated the way a careful host would.
`timescale 1ns/100ps

module mqfs_host_model (
  // Host requests and straps
  input  wire logic polled_i,
  input  wire logic strobe_req_i,
  input  wire logic prog_busy_i,
  // Device pins
  input  wire logic token_out_i,
  output logic      strobe_o,
  output logic      token_in_o
);
  // ---------------------------------------------------------------
  // Pin behaviour
  // ---------------------------------------------------------------
  // Strobe kept low in polled mode and until programming ends
  assign strobe_o = strobe_req_i && !polled_i && !prog_busy_i;
  // Own token looped back when polled, tied low when direct
  assign token_in_o = polled_i && token_out_i;
endmodule
